// ==== supervisor_pkg.sv ====
// Constants, state codes and field positions for the power, reset and clock supervisor.
// Assumes one 25 MHz system clock and inputs that are already synchronous to it.
//
// Contract
// - the block tracks Active, Sleep and Deep Sleep and itself moves between them.
// - in Active every subsystem clock enable is high.
// - in Sleep the processor, flash and SRAM clocks stop, peripherals run, and a wake event returns to Active at once.
// - in Deep Sleep the high-speed clock stops, and resuming takes 35 us.
// - a mode is entered only while supply is adequate, and a brown-out forces a reset; supply is checked only on leaving reset and after Deep Sleep wake.
// - the wake-up interrupt unit restarts the processor from Deep Sleep.
// - clock source changes are glitch-free and pass through a gated gap.
// - the main oscillator starts at 24 MHz and is selectable from 24 to 48 MHz in 4 MHz steps.
// - eight 16-bit peripheral clock dividers run from the high-speed clock, two of them fractional.
// - the watchdog counts low-frequency oscillator ticks, also in Deep Sleep, and forces a reset at timeout.
// - a watchdog reset is logged in the readable reset-cause register.
// - the reset-cause register survives the reset that it records.
// - several sources, software among them, reset the device and return logic to a known state.
package supervisor_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS   = 40;
  localparam int WAKE_TIME_NS    = 35000;
  localparam int WAKE_CYCLES     = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CNT_W      = 10;
  localparam int RST_HOLD_CYCLES = 16;
  localparam int RST_CNT_W       = 5;
  localparam int SWITCH_GAP      = 2;

  // ****************************************
  // main oscillator frequency
  // ****************************************
  localparam logic [5:0] OSC_BASE_MHZ = 6'h18;
  localparam logic [5:0] OSC_STEP_MHZ = 6'h04;
  localparam logic [5:0] OSC_MAX_MHZ  = 6'h30;
  localparam logic [2:0] OSC_SEL_MAX  = 3'h6;

  // ****************************************
  // reset cause bits
  // ****************************************
  localparam int CAUSE_W   = 5;
  localparam int CAUSE_POR = 0;
  localparam int CAUSE_BOD = 1;
  localparam int CAUSE_SW  = 2;
  localparam int CAUSE_WDT = 3;
  localparam int CAUSE_EXT = 4;
  localparam logic [CAUSE_W-1:0] CAUSE_RESET = 5'h01;

  // ****************************************
  // modes and sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    MODE_ACTIVE = 2'b00,
    MODE_SLEEP  = 2'b01,
    MODE_DEEP   = 2'b10,
    MODE_RESET  = 2'b11
  } mode_type;

  typedef enum logic [2:0] {
    ST_RESET  = 3'b000,
    ST_ACTIVE = 3'b001,
    ST_SLEEP  = 3'b010,
    ST_DEEP   = 3'b011,
    ST_WAKE   = 3'b100
  } state_type;

  localparam logic [1:0] SRC_MAIN_OSC = 2'h0;

endpackage

// ==== power_mode_reset_clock_supervisor.sv ====
// Power mode sequencer, reset gatherer, watchdog and clock source control.
// Assumes all inputs are synchronous to clk_i and low_freq_tick_i is a one-cycle tick.
`timescale 1ns/1ps
module power_mode_reset_clock_supervisor #(
  parameter int NUM_DIV  = 8,
  parameter int NUM_FRAC = 2,
  parameter int DIV_W    = 16,
  parameter int FRAC_W   = 5,
  parameter int WDT_W    = 16
) (
  input  wire logic                          clk_i,
  input  wire logic                          rstn_i,
  input  wire logic                          ce_i,
  input  wire logic                          supply_ok_i,
  input  wire logic                          brownout_i,
  input  wire logic                          external_reset_n_i,
  input  wire logic                          sw_reset_req_i,
  input  wire logic                          sleep_req_i,
  input  wire logic                          deep_sleep_req_i,
  input  wire logic                          wake_event_i,
  input  wire logic                          low_freq_tick_i,
  input  wire logic                          wdt_enable_i,
  input  wire logic                          wdt_clear_i,
  input  wire logic [WDT_W-1:0]              wdt_limit_i,
  input  wire logic [supervisor_pkg::CAUSE_W-1:0] cause_clear_i,
  input  wire logic [2:0]                    osc_sel_i,
  input  wire logic [1:0]                    clk_src_sel_i,
  input  wire logic [NUM_DIV*DIV_W-1:0]      div_value_i,
  input  wire logic [NUM_FRAC*FRAC_W-1:0]    div_frac_i,
  output logic                               sys_reset_n_o,
  output supervisor_pkg::mode_type           mode_o,
  output logic                               cpu_clk_en_o,
  output logic                               hf_clk_en_o,
  output logic                               periph_clk_en_o,
  output logic [supervisor_pkg::CAUSE_W-1:0] reset_cause_o,
  output logic [WDT_W-1:0]                   wdt_count_o,
  output logic [5:0]                         osc_freq_mhz_o,
  output logic [1:0]                         clk_src_o,
  output logic                               clk_gate_o,
  output logic [NUM_DIV-1:0]                 div_en_o
);
  import supervisor_pkg::*;

  // refuse shapes the divider and watchdog logic cannot serve
  if (NUM_FRAC > NUM_DIV || NUM_DIV < 1 || DIV_W < 2 || FRAC_W < 1 || WDT_W < 2)
  begin : g_bad_params
    $error("supervisor parameters out of range");
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // ****************************************
  // reset gathering and cause register
  // ****************************************
  logic                 wdt_fire;
  logic                 rst_req;
  logic [RST_CNT_W-1:0] rst_cnt;
  logic [RST_CNT_W-1:0] next_rst_cnt;
  logic                 next_sys_reset_n;
  logic [CAUSE_W-1:0]   next_cause;
  logic [CAUSE_W-1:0]   cause_set;

  always_comb
  begin
    cause_set = '0;
    cause_set[CAUSE_BOD] = brownout_i;
    cause_set[CAUSE_SW]  = sw_reset_req_i;
    cause_set[CAUSE_WDT] = wdt_fire;
    cause_set[CAUSE_EXT] = !external_reset_n_i;
    rst_req = |cause_set;
    next_rst_cnt = rst_cnt;
    if (rst_req)
      next_rst_cnt = RST_CNT_W'(RST_HOLD_CYCLES);
    else if (rst_cnt != '0)
      next_rst_cnt = rst_cnt - 1'b1;
    next_sys_reset_n = !rst_req && (rst_cnt == '0);
    next_cause = (reset_cause_o & ~cause_clear_i) | cause_set;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_cnt       <= RST_CNT_W'(RST_HOLD_CYCLES);
      sys_reset_n_o <= 1'b0;
      reset_cause_o <= CAUSE_RESET;
    end
    else if (ce_i)
    begin
      rst_cnt       <= next_rst_cnt;
      sys_reset_n_o <= next_sys_reset_n;
      reset_cause_o <= next_cause;
    end
  end

  brownout_rst_a: assert property (brownout_i && ce_i |=> !sys_reset_n_o)
    else $error("brown-out did not reset");
  cause_sticky_a: assert property (ce_i && reset_cause_o[CAUSE_EXT] && !cause_clear_i[CAUSE_EXT]
    |=> reset_cause_o[CAUSE_EXT])
    else $error("cause bit lost without clear");

  // ****************************************
  // power mode sequencer
  // ****************************************
  state_type             state;
  state_type             next_state;
  logic [WAKE_CNT_W-1:0] wake_cnt;
  logic [WAKE_CNT_W-1:0] next_wake_cnt;
  mode_type              next_mode;
  logic                  next_cpu_en;
  logic                  next_hf_en;
  logic                  next_periph_en;

  always_comb
  begin
    next_state    = state;
    next_wake_cnt = wake_cnt;
    case (state)
      ST_RESET:
        if (rst_cnt == '0 && !rst_req && supply_ok_i)
          next_state = ST_ACTIVE;
      ST_ACTIVE:
        if (deep_sleep_req_i)
          next_state = ST_DEEP;
        else if (sleep_req_i)
          next_state = ST_SLEEP;
      ST_SLEEP:
        if (wake_event_i)
          next_state = ST_ACTIVE;
      ST_DEEP:
        if (wake_event_i)
        begin
          next_state    = ST_WAKE;
          next_wake_cnt = '0;
        end
      ST_WAKE:
        if (wake_cnt == WAKE_CNT_W'(WAKE_CYCLES - 1))
        begin
          if (supply_ok_i)
            next_state = ST_ACTIVE;
        end
        else
          next_wake_cnt = wake_cnt + 1'b1;
      default:
        next_state = ST_RESET;
    endcase
    if (rst_req)
      next_state = ST_RESET;
    case (next_state)
      ST_ACTIVE: next_mode = MODE_ACTIVE;
      ST_SLEEP:  next_mode = MODE_SLEEP;
      ST_DEEP:   next_mode = MODE_DEEP;
      ST_WAKE:   next_mode = MODE_DEEP;
      default:   next_mode = MODE_RESET;
    endcase
    next_cpu_en    = (next_state == ST_ACTIVE);
    next_hf_en     = (next_state == ST_ACTIVE) || (next_state == ST_SLEEP);
    next_periph_en = next_hf_en;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state           <= ST_RESET;
      wake_cnt        <= '0;
      mode_o          <= MODE_RESET;
      cpu_clk_en_o    <= 1'b0;
      hf_clk_en_o     <= 1'b0;
      periph_clk_en_o <= 1'b0;
    end
    else if (ce_i)
    begin
      state           <= next_state;
      wake_cnt        <= next_wake_cnt;
      mode_o          <= next_mode;
      cpu_clk_en_o    <= next_cpu_en;
      hf_clk_en_o     <= next_hf_en;
      periph_clk_en_o <= next_periph_en;
    end
  end

  sleep_gating_a: assert property (mode_o == MODE_SLEEP |-> !cpu_clk_en_o && periph_clk_en_o)
    else $error("sleep clock gating wrong");
  sleep_wake_a: assert property (state == ST_SLEEP && wake_event_i && ce_i && !rst_req
    |=> state == ST_ACTIVE && cpu_clk_en_o)
    else $error("sleep wake not immediate");
  deep_hf_off_a: assert property (mode_o == MODE_DEEP |-> !hf_clk_en_o)
    else $error("high clock running in deep sleep");
  wake_time_a: assert property (state == ST_WAKE && ce_i && !rst_req
    && wake_cnt < WAKE_CNT_W'(WAKE_CYCLES - 1) |=> state == ST_WAKE)
    else $error("deep sleep wake too early");
  active_en_a: assert property (mode_o == MODE_ACTIVE |-> cpu_clk_en_o && hf_clk_en_o)
    else $error("active mode clock missing");

  // ****************************************
  // watchdog
  // ****************************************
  logic [WDT_W-1:0] next_wdt;

  always_comb
  begin
    next_wdt = wdt_count_o;
    if (!sys_reset_n_o || !wdt_enable_i)
      next_wdt = '0;
    else if (wdt_clear_i && state == ST_ACTIVE)
      next_wdt = '0;
    else if (low_freq_tick_i)
      next_wdt = wdt_count_o + 1'b1;
  end

  assign wdt_fire = wdt_enable_i && sys_reset_n_o && (wdt_count_o >= wdt_limit_i);

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      wdt_count_o <= '0;
    else if (ce_i)
      wdt_count_o <= next_wdt;
  end

  wdt_logged_a: assert property (wdt_fire && ce_i
    |=> reset_cause_o[CAUSE_WDT] && !sys_reset_n_o)
    else $error("watchdog reset not logged");

  // ****************************************
  // oscillator select and glitch-free source switch
  // ****************************************
  logic [1:0] gap_cnt;
  logic [1:0] next_gap_cnt;
  logic [1:0] next_src;
  logic       next_gate;
  logic [5:0] next_freq;
  logic [2:0] sel_clamped;

  always_comb
  begin
    // 24 to 48 MHz in 4 MHz steps
    sel_clamped  = (osc_sel_i > OSC_SEL_MAX) ? OSC_SEL_MAX : osc_sel_i;
    next_src     = clk_src_o;
    next_gate    = clk_gate_o;
    next_freq    = osc_freq_mhz_o;
    next_gap_cnt = gap_cnt;
    // gate off, wait out the gap, then switch and gate on in the same cycle
    if (clk_gate_o)
    begin
      if (clk_src_sel_i != clk_src_o || OSC_BASE_MHZ + OSC_STEP_MHZ * 6'(sel_clamped)
          != osc_freq_mhz_o)
      begin
        next_gate    = 1'b0;
        next_gap_cnt = 2'(SWITCH_GAP);
      end
    end
    else if (gap_cnt != '0)
      next_gap_cnt = gap_cnt - 1'b1;
    else
    begin
      next_src  = clk_src_sel_i;
      next_freq = OSC_BASE_MHZ + OSC_STEP_MHZ * 6'(sel_clamped);
      next_gate = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      clk_src_o      <= SRC_MAIN_OSC;
      osc_freq_mhz_o <= OSC_BASE_MHZ;
      clk_gate_o     <= 1'b1;
      gap_cnt        <= '0;
    end
    else if (ce_i)
    begin
      clk_src_o      <= next_src;
      osc_freq_mhz_o <= next_freq;
      clk_gate_o     <= next_gate;
      gap_cnt        <= next_gap_cnt;
    end
  end

  glitch_free_a: assert property (!$stable(clk_src_o) || !$stable(osc_freq_mhz_o)
    |-> !$past(clk_gate_o))
    else $error("clock changed while ungated");
  osc_range_a: assert property (osc_freq_mhz_o >= OSC_BASE_MHZ && osc_freq_mhz_o <= OSC_MAX_MHZ
    && osc_freq_mhz_o[1:0] == 2'h0)
    else $error("oscillator frequency out of range");

  // ****************************************
  // peripheral clock dividers
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_DIV; gi++)
    begin : g_div
      logic [DIV_W-1:0]  cnt;
      logic [DIV_W-1:0]  next_cnt;
      logic [FRAC_W-1:0] acc;
      logic [FRAC_W-1:0] next_acc;
      logic [FRAC_W:0]   sum;
      logic [FRAC_W-1:0] frac;
      logic              en;
      logic              next_en;

      if (gi < NUM_FRAC)
      begin : g_frac
        assign frac = div_frac_i[gi*FRAC_W +: FRAC_W];
      end
      else
      begin : g_int
        assign frac = '0;
      end

      // 16-bit, fractional carry stretches a period
      always_comb
      begin
        sum      = {1'b0, acc} + {1'b0, frac};
        next_cnt = cnt;
        next_acc = acc;
        next_en  = 1'b0;
        if (hf_clk_en_o)
        begin
          if (cnt == '0)
          begin
            next_en  = 1'b1;
            next_acc = sum[FRAC_W-1:0];
            next_cnt = div_value_i[gi*DIV_W +: DIV_W] + DIV_W'(sum[FRAC_W]);
          end
          else
            next_cnt = cnt - 1'b1;
        end
      end

      always_ff @(posedge clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
        begin
          cnt <= '0;
          acc <= '0;
          en  <= 1'b0;
        end
        else if (ce_i)
        begin
          cnt <= next_cnt;
          acc <= next_acc;
          en  <= next_en;
        end
      end

      assign div_en_o[gi] = en;
    end
  endgenerate

  div_stop_a: assert property (!hf_clk_en_o |=> div_en_o == '0)
    else $error("divider ticking without high clock");

endmodule

// ==== supply_monitor_model.sv ====
// Far-side model: supply monitors, external reset pin and low-frequency tick source.
// Assumes the bench changes its command inputs just after a falling clock edge.
`timescale 1ns/1ps
module supply_monitor_model #(
  parameter int TICK_DIV = 4
) (
  input  wire logic clk_i,
  input  wire logic press_ext_i,
  input  wire logic sag_i,
  input  wire logic supply_low_i,
  output logic      supply_ok_o,
  output logic      brownout_o,
  output logic      external_reset_n_o,
  output logic      low_freq_tick_o
);
  // ****************************************
  // monitors and pin
  // ****************************************
  int tick_cnt = 0;

  assign supply_ok_o = ~supply_low_i;
  assign brownout_o  = sag_i;
  // pin driven low
  // the pull-up brings the pin back high as soon as it is let go
  assign external_reset_n_o = ~press_ext_i;

  // ****************************************
  // low-frequency tick
  // ****************************************
  // divisor is shortened so watchdog timeouts stay inside a short run
  initial low_freq_tick_o = 1'b0;
  always @(negedge clk_i)
  begin
    tick_cnt <= (tick_cnt == TICK_DIV - 1) ? 0 : tick_cnt + 1;
    low_freq_tick_o <= (tick_cnt == TICK_DIV - 1);
  end
endmodule

// ==== tb.sv ====
// Self-checking bench for the power, reset and clock supervisor.
// Assumes inputs change at falling edges and outputs are settled there.
`timescale 1ns/1ps
module tb;
  import supervisor_pkg::*;

  // ****************************************
  // signals
  // ****************************************
  logic                clk_i = 1'b0;
  logic                rstn_i = 1'b0;
  logic                sw_reset_req_i = 1'b0, sleep_req_i = 1'b0, deep_sleep_req_i = 1'b0;
  logic                wake_event_i = 1'b0, wdt_enable_i = 1'b0, wdt_clear_i = 1'b0;
  logic [15:0]         wdt_limit_i = 16'hFFFF;
  logic [CAUSE_W-1:0]  cause_clear_i = '0;
  logic [2:0]          osc_sel_i = 3'h0;
  logic [1:0]          clk_src_sel_i = 2'h0;
  logic [127:0]        div_value_i = '0;
  logic [9:0]          div_frac_i = '0;
  logic                ce_i = 1'b1;
  logic                press = 1'b0, sag = 1'b0, supply_low = 1'b0;
  logic                supply_ok, brownout, ext_n, tick;
  logic                sys_reset_n_o, cpu_clk_en_o, hf_clk_en_o, periph_clk_en_o, clk_gate_o;
  mode_type            mode_o;
  logic [CAUSE_W-1:0]  reset_cause_o;
  logic [15:0]         wdt_count_o;
  logic [5:0]          osc_freq_mhz_o;
  logic [1:0]          clk_src_o;
  logic [7:0]          div_en_o;
  int                  fail_count = 0;
  int                  samples_checked = 0;
  int                  n;
  logic [2:0]          sels [8] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h0, 3'h7};

  always #20 clk_i = ~clk_i;

  supply_monitor_model #(.TICK_DIV(4)) far_side (
    .clk_i(clk_i), .press_ext_i(press), .sag_i(sag), .supply_low_i(supply_low),
    .supply_ok_o(supply_ok), .brownout_o(brownout), .external_reset_n_o(ext_n),
    .low_freq_tick_o(tick));

  power_mode_reset_clock_supervisor uut (
    .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .supply_ok_i(supply_ok),
    .brownout_i(brownout), .external_reset_n_i(ext_n), .sw_reset_req_i(sw_reset_req_i),
    .sleep_req_i(sleep_req_i), .deep_sleep_req_i(deep_sleep_req_i),
    .wake_event_i(wake_event_i), .low_freq_tick_i(tick), .wdt_enable_i(wdt_enable_i),
    .wdt_clear_i(wdt_clear_i), .wdt_limit_i(wdt_limit_i), .cause_clear_i(cause_clear_i),
    .osc_sel_i(osc_sel_i), .clk_src_sel_i(clk_src_sel_i), .div_value_i(div_value_i),
    .div_frac_i(div_frac_i), .sys_reset_n_o(sys_reset_n_o), .mode_o(mode_o),
    .cpu_clk_en_o(cpu_clk_en_o), .hf_clk_en_o(hf_clk_en_o),
    .periph_clk_en_o(periph_clk_en_o), .reset_cause_o(reset_cause_o),
    .wdt_count_o(wdt_count_o), .osc_freq_mhz_o(osc_freq_mhz_o), .clk_src_o(clk_src_o),
    .clk_gate_o(clk_gate_o), .div_en_o(div_en_o));

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk_i);
  endtask

  // bounded wait for the system reset output to reach a level
  task automatic wait_rst(input logic lvl, input int lim);
    int k;
    k = 0;
    while (sys_reset_n_o !== lvl && k < lim)
    begin
      @(negedge clk_i);
      k++;
    end
    check(k < lim, 1'b1);
  endtask

  task automatic clear_cause();
    cause_clear_i = 5'h1F;
    cyc(1);
    cause_clear_i = 5'h00;
    cyc(1);
  endtask

  task automatic sw_clk(input logic [2:0] sel, input logic [1:0] src, input int expf);
    logic gap;
    gap = 1'b0;
    osc_sel_i = sel;
    clk_src_sel_i = src;
    repeat (12)
    begin
      @(negedge clk_i);
      if (clk_gate_o === 1'b0) gap = 1'b1;
    end
    check(gap, 1'b1);
    check(osc_freq_mhz_o, expf);
    check({clk_src_o, clk_gate_o}, {src, 1'b1});
  endtask

  task automatic div_period(input int idx, input int exp);
    int k;
    k = 0;
    while (div_en_o[idx] !== 1'b1 && k < 40)
    begin
      @(negedge clk_i);
      k++;
    end
    k = 0;
    do
    begin
      @(negedge clk_i);
      k++;
    end
    while (div_en_o[idx] !== 1'b1 && k < 40);
    check(k, exp);
  endtask

  // one reset source pressed for two cycles, then released
  task automatic src_reset(input int idx);
    if (idx == CAUSE_SW) sw_reset_req_i = 1'b1;
    if (idx == CAUSE_EXT) press = 1'b1;
    if (idx == CAUSE_BOD) sag = 1'b1;
    cyc(2);
    check(sys_reset_n_o, 1'b0);
    {sw_reset_req_i, press, sag} = 3'b000;
    wait_rst(1'b1, 40);
    check(reset_cause_o, 5'h01 << idx);
    check(mode_o, MODE_ACTIVE);
    clear_cause();
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    for (int i = 0; i < 8; i++) div_value_i[16*i +: 16] = 16'(i + 2);
    cyc(16);
    check({sys_reset_n_o, cpu_clk_en_o, hf_clk_en_o, div_en_o}, 16'h0000);
    check({mode_o, reset_cause_o, clk_src_o, clk_gate_o}, 16'h0309);
    check(osc_freq_mhz_o, 6'h18);
    rstn_i = 1'b1;
    n = 0;
    while (sys_reset_n_o !== 1'b1 && n < 40)
    begin
      @(negedge clk_i);
      n++;
    end
    check(n, 17);
    check({mode_o, cpu_clk_en_o, hf_clk_en_o, periph_clk_en_o}, 5'h07);
    clear_cause();
    check(reset_cause_o, 5'h00);
    sleep_req_i = 1'b1;
    cyc(1);
    sleep_req_i = 1'b0;
    check({mode_o, cpu_clk_en_o, hf_clk_en_o, periph_clk_en_o}, 5'h0B);
    deep_sleep_req_i = 1'b1;
    cyc(1);
    deep_sleep_req_i = 1'b0;
    check(mode_o, MODE_SLEEP);
    wake_event_i = 1'b1;
    cyc(1);
    wake_event_i = 1'b0;
    check({mode_o, cpu_clk_en_o}, 3'h1);
    wdt_enable_i = 1'b1;
    deep_sleep_req_i = 1'b1;
    cyc(1);
    deep_sleep_req_i = 1'b0;
    check({mode_o, cpu_clk_en_o, hf_clk_en_o}, 4'h8);
    cyc(100);
    check(wdt_count_o != 16'h0000, 1'b1);
    // clock enable low must freeze the count although ticks keep arriving
    n = wdt_count_o;
    ce_i = 1'b0;
    cyc(8);
    check(wdt_count_o, n);
    ce_i = 1'b1;
    wake_event_i = 1'b1;
    cyc(1);
    wake_event_i = 1'b0;
    n = 1;
    while (mode_o !== MODE_ACTIVE && n < 2000)
    begin
      @(negedge clk_i);
      n++;
    end
    check(n >= 35000 / 40 && n <= 35000 / 40 + 1, 1'b1);
    wdt_enable_i = 1'b0;
    div_period(2, 5);
    div_period(7, 10);
    // half-step fraction: periods 3, 3, then 4 once the carry comes round
    div_period(0, 3);
    div_frac_i = 10'h010;
    div_period(0, 3);
    div_period(0, 3);
    div_period(0, 4);
    div_frac_i = 10'h000;
    for (int i = 0; i < 8; i++) sw_clk(sels[i], 2'h0, 24 + 4 * ((sels[i] > 6) ? 6 : sels[i]));
    sw_clk(3'h0, 2'h1, 24);
    sw_clk(3'h0, 2'h0, 24);
    wdt_limit_i = 16'h0003;
    wdt_enable_i = 1'b1;
    wdt_clear_i = 1'b1;
    n = 0;
    repeat (60)
    begin
      @(negedge clk_i);
      if (sys_reset_n_o !== 1'b1) n++;
    end
    check(n, 0);
    wdt_clear_i = 1'b0;
    wait_rst(1'b0, 100);
    wdt_enable_i = 1'b0;
    check(reset_cause_o, 5'h08);
    wait_rst(1'b1, 40);
    check(reset_cause_o, 5'h08);
    clear_cause();
    src_reset(CAUSE_SW);
    src_reset(CAUSE_EXT);
    src_reset(CAUSE_BOD);
    supply_low = 1'b1;
    press = 1'b1;
    cyc(2);
    press = 1'b0;
    cyc(40);
    check(mode_o, MODE_RESET);
    supply_low = 1'b0;
    cyc(10);
    check(mode_o, MODE_ACTIVE);
    osc_sel_i = 3'h3;
    cyc(12);
    rstn_i = 1'b0;
    cyc(2);
    check({reset_cause_o, osc_freq_mhz_o}, {5'h01, 6'h18});
    osc_sel_i = 3'h0;
    rstn_i = 1'b1;
    wait_rst(1'b1, 40);
    close_out();
  end

  initial
  begin
    #(20000 * 40);
    fail_count++;
    close_out();
  end
endmodule
